// file: hw/fbc_ctrl.sv
// Host-side controller that drives a parallel flash through its pins.
// Operation
// R1: Device latches commands; host writes them.
// R2: Read with select, gate low, strobe high.
// R3: Deselect floats device data pins.
// R4: Gate high floats device data pins.
// R5: Write with strobe, select low, gate high.
// R6: Plain reads need no command.
// R7: Device starts in array read.
// R8: Reset low aborts; host holds minimum pulse.
// R9: Reset returns device to array read.
// R10: Busy stays low until recovery ends.
// R11: Host waits reset-high delay before reading.
// R12: Host re-issues aborted program or erase; the controller only flags the abort on op_aborted and re-issues nothing.
// R13: System reset resets the flash; sys_rst here leaves reset_n high, and only FBC_OP_RESET pulses it low.
// R14: Identification sequence enables code reads.
// R15: Protect verify returns 00H or 01H.
// R16: Codes via qualifier or command sequence.
// R17: Sector selected by upper address bits.
// R18: Address on later fall, data earlier rise.
// R19: Bad sequence returns device to array read.
// R20: Command F0H leaves identification mode.
// R21: High voltage given as qualifier outputs.
`timescale 1ns/100ps
`include "fbc_defines.svh"
module fbc_ctrl #(
   parameter int unsigned AW          = 19,
   parameter int unsigned READY_CYC   = `FBC_READY_CYC
) (
   // Clock and reset.
   input  wire logic          core_clk,
   input  wire logic          sys_rst,
   // User request port.
   input  wire logic          req_valid,
   output logic               req_ready,
   input  wire fbc_pkg::fbc_op_e req_op,
   input  wire logic [AW-1:0] req_addr,
   input  wire logic [7:0]    req_wdata,
   input  wire logic          req_hv,
   output logic               rsp_valid,
   output logic [7:0]         rsp_rdata,
   output logic               rsp_protected,
   output logic               id_mode,
   output logic               op_aborted,
   // Flash pins.
   output logic [AW-1:0]      address_input,
   input  wire logic [7:0]    data_pins_i,
   output logic [7:0]         data_pins_o,
   output logic               data_pins_oe,
   output logic               chip_sel_n,
   output logic               out_gate_n,
   output logic               wr_strobe_n,
   output logic               reset_n,
   input  wire logic          ready_busy_out,
   output logic               high_voltage_qualifier_reset,
   output logic               high_voltage_qualifier_id
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_RD, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
      ST_RST_LOW, ST_RST_WAIT, ST_RST_HIGH
   } fbc_st_e;

   typedef struct packed {
      fbc_st_e        st;
      fbc_pkg::fbc_op_e op;
      logic [15:0]    cnt;
      logic [1:0]     seq_pos;
      logic [1:0]     seq_len;
      logic           seq_mode;
      logic [AW-1:0]  addr;
      logic [7:0]     wdata;
      logic [7:0]     rdata;
      logic           rsp;
      logic           prot;
      logic           id;
      logic           busy_seen;
      logic           aborted;
      logic           hv_id;
   } fbc_state_s;

   fbc_state_s s_r;
   fbc_state_s s_nxt;
   fbc_seq_if  seq ();

   fbc_seq_rom u_rom (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .seq      (seq)
   );

   function automatic logic [15:0] cyc16(input int unsigned n);
      cyc16 = 16'(n);
   endfunction : cyc16

   assign seq.idx = s_nxt.seq_pos;

   always_comb begin
      s_nxt     = s_r;
      s_nxt.rsp = 1'b0;
      unique case (s_r.st)
         ST_IDLE: begin
            if (req_valid) begin
               s_nxt.op    = req_op;
               s_nxt.addr  = req_addr;
               s_nxt.wdata = req_wdata;
               s_nxt.hv_id = req_hv;
               s_nxt.cnt   = '0;
               unique case (req_op)
                  fbc_pkg::FBC_OP_READ, fbc_pkg::FBC_OP_PROT_CHECK: begin
                     // A protection verify read needs its select bit high.
                     if (req_op == fbc_pkg::FBC_OP_PROT_CHECK) begin
                        s_nxt.addr[`FBC_PROT_BIT] = 1'b1; // R15
                     end
                     s_nxt.st = ST_RD; // R6
                  end
                  fbc_pkg::FBC_OP_WRITE: begin
                     s_nxt.seq_mode = 1'b0;
                     s_nxt.st       = ST_WR_SETUP;
                  end
                  fbc_pkg::FBC_OP_ID_ENTER: begin
                     s_nxt.seq_mode = 1'b1; // R14
                     s_nxt.seq_pos  = 2'h0;
                     s_nxt.seq_len  = 2'h2;
                     s_nxt.st       = ST_WR_SETUP;
                  end
                  fbc_pkg::FBC_OP_ID_EXIT: begin
                     s_nxt.seq_mode = 1'b1; // R20
                     s_nxt.seq_pos  = 2'h3;
                     s_nxt.seq_len  = 2'h3;
                     s_nxt.st       = ST_WR_SETUP;
                  end
                  fbc_pkg::FBC_OP_RESET: begin
                     s_nxt.busy_seen = ~ready_busy_out;
                     s_nxt.st        = ST_RST_LOW; // R13
                  end
                  default: begin
                     s_nxt.st = ST_IDLE;
                  end
               endcase
            end
         end
         ST_RD: begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
            if (s_r.cnt == cyc16(`FBC_ACCESS_CYC)) begin
               s_nxt.rdata = data_pins_i; // R2
               s_nxt.prot  = (s_r.op == fbc_pkg::FBC_OP_PROT_CHECK) &&
                             (data_pins_i == `FBC_PROT_YES); // R15
               s_nxt.rsp   = 1'b1;
               s_nxt.st    = ST_IDLE;
            end
         end
         ST_WR_SETUP: begin
            s_nxt.cnt = '0;
            // Table entries reach the pins one cycle before the strobe
            // falls, so the address is settled when the device takes it.
            if (s_r.seq_mode && s_r.cnt == 16'h0000) begin
               s_nxt.addr  = seq.addr;
               s_nxt.wdata = seq.data;
               s_nxt.cnt   = 16'h0001;
            end else begin
               s_nxt.st = ST_WR_PULSE;
            end
         end
         ST_WR_PULSE: begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
            if (s_r.cnt == cyc16(`FBC_WR_PULSE_CYC - 1)) begin
               s_nxt.st = ST_WR_HOLD; // R18
            end
         end
         ST_WR_HOLD: begin
            if (s_r.seq_mode && s_r.seq_pos != s_r.seq_len) begin
               s_nxt.seq_pos = s_r.seq_pos + 2'h1; // R19
               s_nxt.cnt     = '0;
               s_nxt.st      = ST_WR_SETUP;
            end else begin
               if (s_r.op == fbc_pkg::FBC_OP_ID_ENTER) begin
                  s_nxt.id = 1'b1;
               end else if (s_r.op == fbc_pkg::FBC_OP_ID_EXIT) begin
                  s_nxt.id = 1'b0; // R20
               end else if (s_r.wdata == `FBC_CMD_RESET) begin
                  s_nxt.id = 1'b0; // R20
               end
               s_nxt.rsp = 1'b1;
               s_nxt.st  = ST_IDLE;
            end
         end
         ST_RST_LOW: begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
            if (s_r.cnt == cyc16(`FBC_RESET_PULSE_CYC - 1)) begin
               s_nxt.cnt = '0;
               s_nxt.id  = 1'b0; // R9
               s_nxt.aborted = s_r.busy_seen; // R12
               s_nxt.st  = ST_RST_WAIT; // R8
            end
         end
         ST_RST_WAIT: begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
            if (ready_busy_out || s_r.cnt == cyc16(READY_CYC)) begin
               s_nxt.cnt = '0;
               s_nxt.st  = ST_RST_HIGH; // R10
            end
         end
         ST_RST_HIGH: begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
            if (s_r.cnt == cyc16(`FBC_RESET_HIGH_CYC - 1)) begin
               s_nxt.rsp = 1'b1;
               s_nxt.st  = ST_IDLE; // R11
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Pin drive follows the state; the host floats data except in the write pulse and hold states.
   assign req_ready     = (s_r.st == ST_IDLE);
   assign rsp_valid     = s_r.rsp;
   assign rsp_rdata     = s_r.rdata;
   assign rsp_protected = s_r.prot;
   assign id_mode       = s_r.id;
   assign op_aborted    = s_r.aborted;
   assign address_input = s_r.addr; // R17
   assign data_pins_o   = s_r.wdata;
   assign data_pins_oe  = (s_r.st == ST_WR_PULSE) ||
                          (s_r.st == ST_WR_HOLD); // R4
   assign chip_sel_n    = ~((s_r.st == ST_RD) ||
                            (s_r.st == ST_WR_PULSE)); // R3
   assign out_gate_n    = ~(s_r.st == ST_RD); // R5
   assign wr_strobe_n   = ~(s_r.st == ST_WR_PULSE); // R1
   assign reset_n       = ~(s_r.st == ST_RST_LOW); // R7
   assign high_voltage_qualifier_reset = 1'b0;
   assign high_voltage_qualifier_id    = (s_r.st == ST_RD) &&
                                         s_r.hv_id; // R16 R21
endmodule : fbc_ctrl

// file: hw/fbc_defines.svh
// Constants for the flash bus host controller.
`ifndef FBC_DEFINES_SVH
`define FBC_DEFINES_SVH
`define FBC_CLK_PERIOD_NS    20
`define FBC_ACCESS_NS        90
`define FBC_ACCESS_CYC \
   ((`FBC_ACCESS_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_WR_PULSE_NS      45
`define FBC_WR_PULSE_CYC \
   ((`FBC_WR_PULSE_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_RESET_PULSE_NS   500
`define FBC_RESET_PULSE_CYC \
   ((`FBC_RESET_PULSE_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_RESET_HIGH_NS    50
`define FBC_RESET_HIGH_CYC \
   ((`FBC_RESET_HIGH_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_READY_NS         20000
`define FBC_READY_CYC \
   ((`FBC_READY_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_UNLOCK_ADDR1     19'h00555
`define FBC_UNLOCK_ADDR2     19'h002AA
`define FBC_UNLOCK_DATA1     8'hAA
`define FBC_UNLOCK_DATA2     8'h55
`define FBC_CMD_RESET        8'hF0
`define FBC_CMD_AUTOSEL      8'h90
`define FBC_PROT_BIT         1
`define FBC_PROT_YES         8'h01
`define FBC_PROT_NO          8'h00
`endif

// file: hw/fbc_pkg.sv
// Types for the flash bus host controller.
package fbc_pkg;
   typedef enum logic [2:0] {
      FBC_OP_READ,
      FBC_OP_WRITE,
      FBC_OP_RESET,
      FBC_OP_ID_ENTER,
      FBC_OP_ID_EXIT,
      FBC_OP_PROT_CHECK
   } fbc_op_e;
endpackage : fbc_pkg

// file: hw/fbc_seq_if.sv
// Interface between the controller and its unlock sequence table.
`timescale 1ns/100ps
interface fbc_seq_if;
   logic [1:0]  idx;
   logic [18:0] addr;
   logic [7:0]  data;
   modport ctl (output idx, input addr, input data);
   modport rom (input idx, output addr, output data);
endinterface : fbc_seq_if

// file: hw/fbc_seq_rom.sv
// Registered table of the unlock write cycles.
`timescale 1ns/100ps
`include "fbc_defines.svh"
module fbc_seq_rom (
   // Clock and reset.
   input  wire logic core_clk,
   input  wire logic sys_rst,
   // Table port.
   fbc_seq_if.rom    seq
);
   typedef struct packed {
      logic [18:0] addr;
      logic [7:0]  data;
   } fbc_rom_s;
   fbc_rom_s st_r;
   fbc_rom_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      unique case (seq.idx)
         2'h0: begin
            st_nxt.addr = `FBC_UNLOCK_ADDR1;
            st_nxt.data = `FBC_UNLOCK_DATA1;
         end
         2'h1: begin
            st_nxt.addr = `FBC_UNLOCK_ADDR2;
            st_nxt.data = `FBC_UNLOCK_DATA2;
         end
         2'h2: begin
            st_nxt.addr = `FBC_UNLOCK_ADDR1;
            st_nxt.data = `FBC_CMD_AUTOSEL;
         end
         2'h3: begin
            st_nxt.addr = 19'h00000;
            st_nxt.data = `FBC_CMD_RESET;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign seq.addr = st_r.addr;
   assign seq.data = st_r.data;
endmodule : fbc_seq_rom

// file: tb/fbc_flash_model.sv
// Behavioural flash device that answers the controller's pins.
`timescale 1ns/100ps
module fbc_flash_model #(
   parameter logic [7:0] ID_CODE = 8'h3C // Arbitrary identity value.
) (
   // Bus pins.
   input  wire logic        reset_n,
   input  wire logic        chip_sel_n,
   input  wire logic        out_gate_n,
   input  wire logic        wr_strobe_n,
   input  wire logic [18:0] address_input,
   input  wire logic [7:0]  data_pins_i,
   input  wire logic        high_voltage_qualifier_id,
   output logic [7:0]       flash_q,
   output logic             ready_busy_out,
   // Scenario control.
   input  wire logic        emb
);
   logic [7:0]  last = 8'h00;
   logic [18:0] wa   = 19'h00000;
   logic [1:0]  st   = 2'h0;
   logic        id_r = 1'h0;
   logic        busy = 1'h0;
   wire drv = reset_n && !chip_sel_n && !out_gate_n && wr_strobe_n;
   wire wrs = wr_strobe_n || chip_sel_n || !reset_n;
   wire idr = id_r || high_voltage_qualifier_id;
   wire [7:0] val = !idr ? address_input[7:0] ^ 8'hA5 :
      address_input[1] ? {7'h00, address_input[18]} : ID_CODE;
   // A released bus shows the inverse of the last byte, never a stale copy.
   always @* if (drv) last = val;
   assign flash_q = drv ? val : ~last;
   assign ready_busy_out = !busy;
   always @(negedge wrs) wa = address_input;
   always @(posedge wrs or negedge reset_n)
      if (!reset_n) begin
         st = 2'h0;
         id_r = 1'h0;
      end else if (data_pins_i == 8'hF0) begin
         st = 2'h0;
         id_r = 1'h0;
      end else if (st == 2'h0 && wa == 19'h00555 && data_pins_i == 8'hAA)
         st = 2'h1;
      else if (st == 2'h1 && wa == 19'h002AA && data_pins_i == 8'h55)
         st = 2'h2;
      else begin
         if (st == 2'h2 && wa == 19'h00555 && data_pins_i == 8'h90)
            id_r = 1'h1;
         st = 2'h0;
      end
   always @(posedge emb or negedge reset_n)
      if (!reset_n) busy <= #810 1'h0;
      else busy = 1'h1;
endmodule : fbc_flash_model

// file: tb/fbc_ctrl_assertions.sv
// Concurrent checks on the flash controller's pins and answers.
`timescale 1ns/100ps
module fbc_ctrl_assertions (
   // Clock and reset.
   input wire logic             core_clk,
   input wire logic             sys_rst,
   // Requests and answers.
   input wire logic             req_valid,
   input wire logic             req_ready,
   input wire fbc_pkg::fbc_op_e req_op,
   input wire logic             rsp_valid,
   // Flash pins.
   input wire logic [18:0]      address_input,
   input wire logic [7:0]       data_pins_o,
   input wire logic             data_pins_oe,
   input wire logic             chip_sel_n,
   input wire logic             out_gate_n,
   input wire logic             wr_strobe_n,
   input wire logic             reset_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic [9:0] low_r;
   wire take = req_valid && req_ready;
   always_ff @(posedge core_clk) low_r <= reset_n ? 10'h000 : low_r + 10'h001;
   a_idle_after_rst: assert property (
      $fell(sys_rst) |-> chip_sel_n && out_gate_n && wr_strobe_n && reset_n)
      else $error("pins busy after reset");
   a_rd_gate_ok: assert property (
      !out_gate_n |-> !chip_sel_n && wr_strobe_n && !data_pins_oe)
      else $error("bad read cycle");
   a_wr_gate_ok: assert property (
      !wr_strobe_n |-> !chip_sel_n && out_gate_n && data_pins_oe)
      else $error("bad write cycle");
   a_wr_held: assert property (
      !wr_strobe_n && !$past(wr_strobe_n) |-> $stable(address_input)
      && $stable(data_pins_o)) else $error("write changed mid pulse");
   a_wr_rise_data: assert property (
      $rose(wr_strobe_n) |-> data_pins_oe) else $error("data gone at rise");
   a_rd_latency: assert property (
      take && req_op == fbc_pkg::FBC_OP_READ |-> !rsp_valid [*7] ##1 rsp_valid)
      else $error("read answer late");
   a_wr_latency: assert property (
      take && req_op == fbc_pkg::FBC_OP_WRITE |-> !rsp_valid [*6] ##1 rsp_valid)
      else $error("write answer late");
   a_rst_len: assert property (
      $rose(reset_n) |-> low_r >= 10'h019) else $error("reset pulse short");
   a_rst_settle: assert property (
      $rose(reset_n) |-> out_gate_n [*3]) else $error("read too soon");
   c_read: cover property (take && req_op == fbc_pkg::FBC_OP_READ);
   c_write: cover property (take && req_op == fbc_pkg::FBC_OP_WRITE);
   c_reset: cover property ($rose(reset_n));
endmodule : fbc_ctrl_assertions
bind fbc_ctrl fbc_ctrl_assertions u_chk (.*);

// file: tb/fbc_ctrl_tb.sv
// Self-checking bench for the flash bus host controller.
`timescale 1ns/100ps
module fbc_ctrl_tb;
   localparam logic [7:0] ID = 8'h3C;
   logic core_clk = 1'h0, sys_rst = 1'h1, req_valid = 1'h0, req_hv = 1'h0;
   logic emb = 1'h0;
   fbc_pkg::fbc_op_e req_op = fbc_pkg::FBC_OP_READ;
   logic [18:0] req_addr = 19'h00000, address_input;
   logic [7:0] req_wdata = 8'h00, rsp_rdata, data_pins_o, flash_q;
   logic req_ready, rsp_valid, rsp_protected, id_mode, op_aborted;
   logic data_pins_oe, chip_sel_n, out_gate_n, wr_strobe_n, reset_n;
   logic ready_busy_out, high_voltage_qualifier_reset;
   logic high_voltage_qualifier_id;
   wire [7:0] data_pins_i = data_pins_oe ? data_pins_o : flash_q;
   int fail_count = 0;
   int compares = 0;
   fbc_ctrl #(.READY_CYC(60)) u_dut (.*);
   fbc_flash_model #(.ID_CODE(ID)) u_flash (.*);
   always #10 core_clk = !core_clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test;
      if (fail_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   // Entered at a rising edge; returns at the edge that shows rsp_valid.
   task automatic do_op(input fbc_pkg::fbc_op_e o, input logic [18:0] a,
                        input logic [7:0] d, input logic h);
      int n;
      n = 0;
      req_valid <= 1'h1;
      req_op <= o;
      req_addr <= a;
      req_wdata <= d;
      req_hv <= h;
      do @(posedge core_clk); while (req_ready !== 1'h1);
      req_valid <= 1'h0;
      do @(posedge core_clk); while (rsp_valid !== 1'h1 && ++n < 3000);
      chk({7'h00, rsp_valid}, 8'h01);
   endtask : do_op
   task automatic rd(input logic [18:0] a, input logic h, input logic [7:0] e);
      do_op(fbc_pkg::FBC_OP_READ, a, 8'h00, h);
      chk(rsp_rdata, e);
   endtask : rd
   task automatic wr(input logic [18:0] a, input logic [7:0] d);
      do_op(fbc_pkg::FBC_OP_WRITE, a, d, 1'h0);
   endtask : wr
   task automatic prot(input logic [18:0] a, input logic [7:0] e);
      do_op(fbc_pkg::FBC_OP_PROT_CHECK, a, 8'h00, 1'h0);
      chk(rsp_rdata, e);
      chk({7'h00, rsp_protected}, e);
   endtask : prot
   task automatic t_read;
      rd(19'h12345, 1'h0, 8'hE0);
      rd(19'h7FFFF, 1'h0, 8'h5A);
   endtask : t_read
   task automatic t_bad_seq;
      wr(19'h00555, 8'hAA);
      wr(19'h002AA, 8'h12);
      wr(19'h00555, 8'h90);
      rd(19'h00003, 1'h0, 8'hA6);
   endtask : t_bad_seq
   task automatic t_id;
      do_op(fbc_pkg::FBC_OP_ID_ENTER, 19'h00000, 8'h00, 1'h0);
      chk({7'h00, id_mode}, 8'h01);
      rd(19'h00000, 1'h0, ID);
      prot(19'h40000, 8'h01);
      prot(19'h3E000, 8'h00);
      do_op(fbc_pkg::FBC_OP_ID_EXIT, 19'h00000, 8'h00, 1'h0);
      chk({7'h00, id_mode}, 8'h00);
      rd(19'h00011, 1'h0, 8'hB4);
      rd(19'h00000, 1'h1, ID);
   endtask : t_id
   task automatic t_reset;
      time t0;
      emb <= 1'h1;
      t0 = $time;
      do_op(fbc_pkg::FBC_OP_RESET, 19'h00000, 8'h00, 1'h0);
      chk({7'h00, op_aborted}, 8'h01);
      // The model stays busy 810 ns past the reset fall; recovery waits.
      chk({7'h00, ($time - t0) >= 880}, 8'h01);
      emb <= 1'h0;
      do_op(fbc_pkg::FBC_OP_ID_ENTER, 19'h00000, 8'h00, 1'h0);
      do_op(fbc_pkg::FBC_OP_RESET, 19'h00000, 8'h00, 1'h0);
      chk({7'h00, op_aborted}, 8'h00);
      chk({7'h00, id_mode}, 8'h00);
      rd(19'h00000, 1'h0, 8'hA5);
   endtask : t_reset
   initial begin
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'h0;
      t_read();
      t_bad_seq();
      t_id();
      t_reset();
      finish_test();
   end
   // The run needs well under a thousand cycles; this allows twenty times that.
   initial begin
      #400000;
      fail_count++;
      finish_test();
   end
endmodule : fbc_ctrl_tb
